// [adc_ctl_map.svh]
/*
  constant map of the converter control block: codes, counts and reset values.
  assumes inclusion by bare name from any file that needs the figures.
*/
`ifndef ADC_CTL_MAP_SVH
`define ADC_CTL_MAP_SVH

// result geometry
`define ADC_RES_BITS      10
`define ADC_RES_MSB       4'd9
// half conversion-clock periods: 11.5 periods = 23 halves
`define ADC_HALF_TOTAL    5'd23
`define ADC_HALF_FIRST    5'd3
`define ADC_HALF_LAST     5'd21
// channel select codes
`define ADC_CH_PIN_LAST   5'h0b
`define ADC_CH_TEMP       5'h1d
`define ADC_CH_DAC        5'h1e
`define ADC_CH_FIXREF     5'h1f
`define ADC_CH_IDX_TEMP   12
`define ADC_CH_IDX_DAC    13
`define ADC_CH_IDX_FIXREF 14
`define ADC_CH_COUNT      15
// positive reference codes
`define ADC_PREF_PIN      2'h0
`define ADC_PREF_SUPPLY   2'h1
`define ADC_PREF_FIX2V    2'h2
`define ADC_PREF_FIX4V    2'h3
// conversion clock select: low two bits 11 mean internal rc oscillator
`define ADC_CLK_RC        2'h3
// reset values
`define ADC_RESULT_RST    8'h00
`define ADC_CODE_RST      10'h000
`define ADC_HALF_RST      5'h00

`endif

// [adc_ctl_pkg.sv]
/*
  types shared by the converter control block and its two helpers.
  assumes adc_ctl_map.svh holds every numeric figure.
*/
package adc_ctl_pkg;

  // sequencer states
  typedef enum logic [1:0] {st_idle, st_wait_instr, st_convert} conv_state_t;

  // software configuration bits, sampled as one group
  typedef struct packed {
    logic [4:0] channel_select_field;
    logic [1:0] positive_reference_select;
    logic       negative_reference_select;
    logic [2:0] conversion_clock_select;
    logic       result_format_select;
  } conv_cfg_t;

  // the result register pair
  typedef struct packed {
    logic [7:0] result_high_reg;
    logic [7:0] result_low_reg;
  } result_pair_t;

endpackage : adc_ctl_pkg

// [conv_clock_gen.sv]
/*
  conversion clock generator: one pulse per half conversion-clock period,
  from the system clock divided by 2..64 or from both edges of the rc oscillator.
  assumes i_rc_level is already synchronised to i_mclk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctl_map.svh"

module conv_clock_gen
  import adc_ctl_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic [2:0] i_sel,
  input  wire logic       i_rc_level,
  output var  logic       o_half_tick
);

  logic [5:0] div_cnt;
  logic       rc_prev;
  logic [5:0] half_len;
  logic       use_rc;
  logic       div_hit;

  // code order is not monotonic: rotating the bits gives the half-period exponent
  assign use_rc   = (i_sel[1:0] == `ADC_CLK_RC);
  assign half_len = 6'(6'h01 << {i_sel[1:0], i_sel[2]});
  assign div_hit  = (div_cnt == 6'(half_len - 6'h01));

  // divider restarts with each conversion so the first half period is whole
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n || !i_run)
    begin
      div_cnt     <= 6'h00;
      o_half_tick <= 1'b0;
    end
    else if (use_rc)
    begin
      div_cnt     <= 6'h00;
      o_half_tick <= (i_rc_level != rc_prev);
    end
    else
    begin
      div_cnt     <= div_hit ? 6'h00 : 6'(div_cnt + 6'h01);
      o_half_tick <= div_hit;
    end
  end

  // previous rc level for edge detection; reads the second sync stage only
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      rc_prev <= 1'b0;
    else
      rc_prev <= i_rc_level;
  end

endmodule : conv_clock_gen

`default_nettype wire

// [result_store.sv]
/*
  result register pair: fills unresolved bits from the last resolved bit,
  then justifies left or right.
  assumes i_load is a one-cycle pulse from the sequencer.
*/
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctl_map.svh"

module result_store
  import adc_ctl_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_load,
  input  wire logic [9:0] i_code,
  input  wire logic [3:0] i_resolved,
  input  wire logic       i_left,
  output var  result_pair_t o_pair
);

  logic [9:0] filled;

  // bits below the last resolved one copy it; nothing resolved leaves the code
  function automatic logic [9:0] fill_partial(input logic [9:0] code, input logic [3:0] n);
    logic [9:0] r;
    logic [3:0] last;
    r    = code;
    last = 4'(4'd10 - n);
    for (int i = 0; i < `ADC_RES_BITS; i++)
      if (n != 4'd0 && 4'(i) < last)
        r[i] = code[last];
    return r;
  endfunction : fill_partial

  assign filled = fill_partial(i_code, i_resolved);

  // contents change only on a load pulse, so they hold through a conversion
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      o_pair <= {`ADC_RESULT_RST, `ADC_RESULT_RST};
    else if (i_load)
      o_pair <= i_left ? {filled, 6'h00} : {6'h00, filled};
  end

endmodule : result_store

`default_nettype wire

// [adc_conversion_control.sv]
/*
  control logic of a 10-bit successive-approximation converter: input and
  reference selection, conversion clock, start, completion, abort, result
  justification, completion flag and sleep behaviour.
  assumes software bits and i_instr_tick, i_sleep come from the core on i_mclk;
  i_rc_osc and i_compare arrive from outside the clock domain.

  // Notes on behaviour
  // - channel field joins one of fifteen sources
  // - positive reference: pin, supply, 2V048, 4V096
  // - negative reference: pin or ground
  // - clock field picks divide 2..64 or rc
  // - one bit per period, 11.5 periods total
  // - done flag set on every completion
  // - enabled completion requests interrupt, wakes sleep
  // - format bit justifies result left or right
  // - enabled converter starts on go write one
  // - completion clears go, sets flag, loads result
  // - software abort loads partial, filled result
  // - reset clears controls, aborts any conversion
  // - rc clock delays start one instruction cycle
  // - rc sleep finish without interrupt powers down
  // - sleep aborts non-rc conversion, powers down
  // - channel codes map pins, temp, dac, reference
  // - enable low means off, no current
*/
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctl_map.svh"

module adc_conversion_control
  import adc_ctl_pkg::*;
#(
  parameter bit LOW_VOLTAGE = 1'b0
)
(
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic         i_converter_enable_bit,
  input  wire conv_cfg_t    i_cfg,
  input  wire logic         i_go_write_one,
  input  wire logic         i_go_write_zero,
  input  wire logic         i_flag_clear,
  input  wire logic         i_conversion_irq_enable,
  input  wire logic         i_sleep,
  input  wire logic         i_instr_tick,
  input  wire logic         i_rc_osc,
  input  wire logic         i_compare,
  output var  logic         o_go_done,
  output var  logic         o_conversion_done_flag,
  output var  logic         o_irq_request,
  output var  logic         o_wake,
  output var  logic         o_converter_powered,
  output var  logic         o_sample_hold,
  output var  logic [9:0]   o_trial_code,
  output var  logic [14:0]  o_channel_connect,
  output var  logic [3:0]   o_pref_connect,
  output var  logic         o_nref_pin,
  output var  result_pair_t o_result
);

  conv_state_t state;
  conv_state_t next_state;
  logic        rc_meta;
  logic        rc_sync;
  logic        cmp_meta;
  logic        cmp_sync;
  logic        half_tick;
  logic [4:0]  half_cnt;
  logic [4:0]  half_next;
  logic [9:0]  sar;
  logic [3:0]  resolved;
  logic [3:0]  bit_pos;
  logic        rc_mode;
  logic        resolve_now;
  logic        finish_now;
  logic        sw_abort;
  logic        sleep_abort;
  logic        load_result;
  logic        sleep_down;
  logic        converting;
  logic [14:0] next_channel;
  logic [3:0]  next_pref;

  // channel code to one-hot connection; unlisted codes connect nothing
  function automatic logic [14:0] channel_decode(input logic [4:0] code);
    logic [14:0] r;
    r = 15'h0000;
    for (int i = 0; i <= `ADC_CH_PIN_LAST; i++)
      if (code == 5'(i))
        r[i] = 1'b1;
    r[`ADC_CH_IDX_TEMP]   = (code == `ADC_CH_TEMP);
    r[`ADC_CH_IDX_DAC]    = (code == `ADC_CH_DAC);
    r[`ADC_CH_IDX_FIXREF] = (code == `ADC_CH_FIXREF);
    return r;
  endfunction : channel_decode

  // two-stage synchronisers for the rc oscillator and comparator pins
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      rc_meta  <= 1'b0;
      rc_sync  <= 1'b0;
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end
    else
    begin
      rc_meta  <= i_rc_osc;
      rc_sync  <= rc_meta;
      cmp_meta <= i_compare;
      cmp_sync <= cmp_meta;
    end
  end

  conv_clock_gen u_clock
  (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_run       (converting),
    .i_sel       (i_cfg.conversion_clock_select),
    .i_rc_level  (rc_sync),
    .o_half_tick (half_tick)
  );

  // sequencing terms
  assign converting  = (state == st_convert);
  assign rc_mode     = (i_cfg.conversion_clock_select[1:0] == `ADC_CLK_RC);
  assign half_next   = 5'(half_cnt + 5'h01);
  // bits resolve at the end of each whole period after the first half period
  assign resolve_now = converting && half_tick && half_next[0]
                       && half_next >= `ADC_HALF_FIRST && half_next <= `ADC_HALF_LAST;
  assign finish_now  = converting && half_tick && half_next == `ADC_HALF_TOTAL;
  assign bit_pos     = 4'(`ADC_RES_MSB - resolved);
  // the sleep abort takes no result: nothing said it should, and it costs nothing
  assign sw_abort    = converting && i_go_write_zero && !finish_now;
  assign sleep_abort = (state != st_idle) && i_sleep && !rc_mode;
  assign load_result = finish_now || sw_abort;

  // next state
  always_comb
  begin
    next_state = state;
    case (state)
      st_idle:
        if (i_converter_enable_bit && i_go_write_one && !sleep_down)
          next_state = rc_mode ? st_wait_instr : st_convert;
      st_wait_instr:
        if (i_instr_tick)
          next_state = st_convert;
      st_convert:
        if (finish_now)
          next_state = st_idle;
      default:
        next_state = st_idle;
    endcase
    if (!i_converter_enable_bit || i_go_write_zero || sleep_abort)
      next_state = st_idle;
  end

  // state, go bit and successive approximation register
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      state     <= st_idle;
      o_go_done <= 1'b0;
      half_cnt  <= `ADC_HALF_RST;
      sar       <= `ADC_CODE_RST;
      resolved  <= 4'h0;
    end
    else
    begin
      state     <= next_state;
      o_go_done <= (next_state != st_idle);
      if (!converting)
      begin
        half_cnt <= `ADC_HALF_RST;
        sar      <= `ADC_CODE_RST;
        resolved <= 4'h0;
      end
      else
      begin
        if (half_tick)
          half_cnt <= half_next;
        if (resolve_now)
        begin
          sar[bit_pos] <= cmp_sync;
          resolved     <= 4'(resolved + 4'h1);
        end
      end
    end
  end

  // trial code offered to the comparator dac: decided bits plus the bit on test
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      o_trial_code <= `ADC_CODE_RST;
    else if (converting && resolved < 4'd10)
      o_trial_code <= sar | 10'(10'h001 << bit_pos);
    else
      o_trial_code <= sar;
  end

  result_store u_result
  (
    .i_mclk     (i_mclk),
    .i_rst_n    (i_rst_n),
    .i_load     (load_result),
    .i_code     (sar),
    .i_resolved (resolved),
    .i_left     (i_cfg.result_format_select),
    .o_pair     (o_result)
  );

  // done flag: completion sets, software clears, a set in the clear cycle wins
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      o_conversion_done_flag <= 1'b0;
    else if (finish_now)
      o_conversion_done_flag <= 1'b1;
    else if (i_flag_clear)
      o_conversion_done_flag <= 1'b0;
  end

  // interrupt request follows the flag one cycle late; wake only while asleep
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_irq_request <= 1'b0;
      o_wake        <= 1'b0;
    end
    else
    begin
      o_irq_request <= o_conversion_done_flag && i_conversion_irq_enable;
      o_wake        <= o_conversion_done_flag && i_conversion_irq_enable && i_sleep;
    end
  end

  // sleep power-down latch: enable bit is left alone, released on leaving sleep
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      sleep_down <= 1'b0;
    else if (!i_sleep)
      sleep_down <= 1'b0;
    else if (finish_now && !i_conversion_irq_enable)
      sleep_down <= 1'b1;
    else if (sleep_abort || (i_sleep && !rc_mode && state == st_idle))
      sleep_down <= 1'b1;
  end

  // analog selections, registered so the mux control never glitches
  assign next_channel = channel_decode(i_cfg.channel_select_field);
  always_comb
  begin
    next_pref = 4'h0;
    case (i_cfg.positive_reference_select)
      `ADC_PREF_PIN:    next_pref[0] = 1'b1;
      `ADC_PREF_SUPPLY: next_pref[1] = 1'b1;
      `ADC_PREF_FIX2V:  next_pref[2] = 1'b1;
      `ADC_PREF_FIX4V:  next_pref[3] = !LOW_VOLTAGE;
      default:          next_pref    = 4'h0;
    endcase
  end

  // power and connections; the sample switch tracks except during a conversion
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_converter_powered <= 1'b0;
      o_sample_hold       <= 1'b0;
      o_channel_connect   <= 15'h0000;
      o_pref_connect      <= 4'h0;
      o_nref_pin          <= 1'b0;
    end
    else
    begin
      o_converter_powered <= i_converter_enable_bit && !sleep_down && !sleep_abort;
      o_sample_hold       <= (next_state == st_convert);
      o_channel_connect   <= i_converter_enable_bit ? next_channel : 15'h0000;
      o_pref_connect      <= next_pref;
      o_nref_pin          <= !i_cfg.negative_reference_select;
    end
  end

endmodule : adc_conversion_control

`default_nettype wire

// [adc_analog_model.sv]
/*
  analog side model: comparator of a held input level against the trial code.
  assumes the bench sets the level before each conversion starts.
*/
`timescale 1ns/1ns
`default_nettype none

module adc_analog_model
(
  input  wire logic [9:0] i_trial,
  input  wire logic [9:0] i_level,
  output var  logic       o_compare
);
  // answers at once; at the fastest divide the trial code settles late
  always_comb o_compare = (i_level >= i_trial);
endmodule : adc_analog_model

`default_nettype wire

// [adc_conversion_control_chk.sv]
/*
  port checker for the converter control block.
  assumes it is bound onto adc_conversion_control.
*/
`timescale 1ns/1ns
`default_nettype none

module adc_conversion_control_chk
  import adc_ctl_pkg::*;
#(
  parameter bit LOW_VOLTAGE = 1'b0
)
(
  input wire logic         i_mclk,
  input wire logic         i_rst_n,
  input wire logic         i_converter_enable_bit,
  input wire conv_cfg_t    i_cfg,
  input wire logic         i_go_write_one,
  input wire logic         i_go_write_zero,
  input wire logic         i_flag_clear,
  input wire logic         i_conversion_irq_enable,
  input wire logic         i_sleep,
  input wire logic         o_go_done,
  input wire logic         o_conversion_done_flag,
  input wire logic         o_irq_request,
  input wire logic         o_wake,
  input wire logic         o_converter_powered,
  input wire logic [14:0]  o_channel_connect,
  input wire logic [3:0]   o_pref_connect,
  input wire logic         o_nref_pin,
  input wire result_pair_t o_result
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  // expected routing; unlisted channel codes connect nothing
  wire logic [4:0]  ch       = i_cfg.channel_select_field;
  wire logic [1:0]  ps       = i_cfg.positive_reference_select;
  wire logic        rc_sel   = &i_cfg.conversion_clock_select[1:0];
  wire logic [14:0] exp_chan = (ch <= 5'h0b) ? 15'h0001 << ch : (ch >= 5'h1d) ? 15'h0001 << (ch - 5'h11) : 15'h0000;
  wire logic [3:0]  exp_pref = (LOW_VOLTAGE && &ps) ? 4'h0 : 4'h1 << ps;

  a_go_start: assert property (
    i_go_write_one && !i_go_write_zero && i_converter_enable_bit && !o_go_done && !i_sleep |=> o_go_done)
    else $error("go request not taken");
  a_disable_stop: assert property (
    !i_converter_enable_bit |=> !o_go_done && o_channel_connect == 15'h0000) else $error("disabled but active");
  a_abort_stop: assert property (
    o_go_done && i_go_write_zero |=> !o_go_done) else $error("abort ignored");
  a_flag_sticky: assert property (
    o_conversion_done_flag && !i_flag_clear |=> o_conversion_done_flag) else $error("flag lost");
  a_flag_at_end: assert property (
    $rose(o_conversion_done_flag) |-> !o_go_done && ($past(o_go_done) || $past(o_go_done, 2)))
    else $error("flag without completion");
  a_result_hold: assert property (
    $changed(o_result) |-> $past(o_go_done) || $past(o_go_done, 2) || !$past(i_rst_n)) else $error("result moved");
  a_irq_request: assert property (
    (o_conversion_done_flag && i_conversion_irq_enable) [*2] |-> o_irq_request) else $error("no request");
  a_wake_sleep: assert property (
    (o_irq_request && i_conversion_irq_enable && i_sleep) [*2] |-> o_wake) else $error("no wake");
  a_sleep_abort: assert property (
    o_go_done && i_sleep && !rc_sel |=> !o_go_done && !o_converter_powered) else $error("sleep abort missed");
  a_route_map: assert property (
    i_converter_enable_bit && !i_sleep ##1 i_converter_enable_bit && !i_sleep && $stable(i_cfg) |->
    o_channel_connect == exp_chan && o_pref_connect == exp_pref && o_nref_pin == !i_cfg.negative_reference_select)
    else $error("routing wrong");

  c_complete: cover property ($rose(o_conversion_done_flag));
  c_abort: cover property (o_go_done && i_go_write_zero);
  c_wake: cover property ($rose(o_wake));
endmodule : adc_conversion_control_chk

bind adc_conversion_control adc_conversion_control_chk #(.LOW_VOLTAGE(LOW_VOLTAGE)) i_chk (.i_mclk, .i_rst_n,
  .i_converter_enable_bit, .i_cfg, .i_go_write_one, .i_go_write_zero, .i_flag_clear, .i_conversion_irq_enable,
  .i_sleep, .o_go_done, .o_conversion_done_flag, .o_irq_request, .o_wake, .o_converter_powered,
  .o_channel_connect, .o_pref_connect, .o_nref_pin, .o_result);

`default_nettype wire

// [tb.sv]
/*
  self-checking bench: routing, dividers, abort, sleep, rc start and reset.
  assumes the analog model answers combinationally to the trial code.
*/
`timescale 1ns/1ns
`default_nettype none

module tb
  import adc_ctl_pkg::*;
;
  logic         mclk = 0, rst_n = 0, en = 0, go1 = 0, go0 = 0, fclr = 0;
  logic         irq_en = 0, slp = 0, itick = 0, rc = 0;
  conv_cfg_t    cfg = '0;
  logic [9:0]   level = '0;
  wire logic    cmp, go_done, flag, irq, wake, pwr, sh, nref;
  wire logic [9:0]  trial;
  wire logic [14:0] chan;
  wire logic [3:0]  pref;
  result_pair_t res;
  int           n_mismatch = 0, n_checks = 0, cycles = 0, n, k;
  integer       seed = 32'h7e66;
  int           divs [6] = '{2, 4, 8, 16, 32, 64};
  logic [2:0]   sels [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};

  always #25 mclk = ~mclk;
  // free-running rc oscillator, phase unrelated to mclk
  always #437 rc = ~rc;

  adc_conversion_control i_adc_conversion_control (.i_mclk(mclk), .i_rst_n(rst_n), .i_converter_enable_bit(en),
    .i_cfg(cfg), .i_go_write_one(go1), .i_go_write_zero(go0), .i_flag_clear(fclr),
    .i_conversion_irq_enable(irq_en), .i_sleep(slp), .i_instr_tick(itick), .i_rc_osc(rc), .i_compare(cmp),
    .o_go_done(go_done), .o_conversion_done_flag(flag), .o_irq_request(irq), .o_wake(wake),
    .o_converter_powered(pwr), .o_sample_hold(sh), .o_trial_code(trial), .o_channel_connect(chan),
    .o_pref_connect(pref), .o_nref_pin(nref), .o_result(res));
  adc_analog_model i_adc_analog_model (.i_trial(trial), .i_level(level), .o_compare(cmp));

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // a hang ends the run through the same report
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
    #5;
  endtask : cyc

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic result_pair_t just(input logic [9:0] r, input logic left);
    return left ? {r, 6'h00} : {6'h00, r};
  endfunction : just

  function automatic logic [14:0] chmap(input logic [4:0] c);
    if (c <= 5'h0b)
      return 15'h0001 << c;
    return (c >= 5'h1d) ? 15'h0001 << (c - 5'h11) : 15'h0000;
  endfunction : chmap

  task automatic pulse_go();
    go1 = 1;
    cyc(1);
    go1 = 0;
  endtask : pulse_go

  // settings a cycle ahead of go, as the acquisition wait asks
  task automatic start(input logic [2:0] sel);
    cfg.conversion_clock_select = sel;
    cfg.result_format_select = 1'($random(seed));
    cyc(1);
    pulse_go();
  endtask : start

  task automatic wait_done(output int c);
    c = 0;
    while (go_done === 1'b1 && c < 2000)
    begin
      cyc(1);
      c++;
    end
    // a conversion that never ends counts here after 2000 cycles, well before the timeout
    chk(go_done, 1'b0);
  endtask : wait_done

  initial
  begin
    cyc(10);
    rst_n = 1;
    chk({go_done, flag, irq, res}, 20'h0);
    pulse_go();
    chk(go_done, 1'b0);
    en = 1;
    cyc(1);
    // every channel code, with references cycling alongside
    for (int c = 0; c < 32; c++)
    begin
      cfg.channel_select_field = c[4:0];
      cfg.positive_reference_select = c[1:0];
      cfg.negative_reference_select = c[2];
      cyc(2);
      chk(chan, chmap(c[4:0]));
      chk({pref, nref}, {4'h1 << c[1:0], ~c[2]});
    end
    // each divider with a busy go repeated; the run length must fall within -1..4 cycles of 11.5 periods
    foreach (sels[i])
    begin
      level = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'($random(seed));
      irq_en = 1'($random(seed));
      start(sels[i]);
      cyc(2);
      pulse_go();
      wait_done(n);
      k = n + 3 - 23 * divs[i] / 2;
      chk(k >= -1 && k <= 4, 1'b1);
      cyc(2);
      chk(res, just(level, cfg.result_format_select));
      cyc(5);
      chk({flag, irq}, {1'b1, irq_en});
      fclr = 1;
      cyc(1);
      fclr = 0;
      cyc(2);
      chk(flag, 1'b0);
    end
    // software abort after two bits at divide 64
    level = 10'($random(seed));
    start(3'h6);
    cyc(190);
    go0 = 1;
    cyc(1);
    go0 = 0;
    cyc(2);
    chk({go_done, flag}, 2'b00);
    chk(res, just({level[9:8], {8{level[8]}}}, cfg.result_format_select));
    // sleep during a divided-clock conversion
    start(3'h1);
    cyc(20);
    chk({go_done, pwr, sh}, 3'b111);
    slp = 1;
    cyc(2);
    chk({go_done, pwr, flag, sh}, 4'b0000);
    slp = 0;
    cyc(2);
    // rc clock in sleep: waits for an instruction cycle, then powers down
    irq_en = 0;
    level = 10'($random(seed));
    // either code of the x11 pattern selects the rc oscillator
    start({1'($random(seed)), 2'b11});
    slp = 1;
    cyc(300);
    chk(go_done, 1'b1);
    itick = 1;
    cyc(1);
    itick = 0;
    wait_done(n);
    cyc(3);
    chk({flag, pwr, wake, en}, 4'b1001);
    chk(res, just(level, cfg.result_format_select));
    irq_en = 1;
    cyc(3);
    chk({irq, wake}, 2'b11);
    slp = 0;
    // reset in mid-conversion
    start(3'h2);
    cyc(10);
    rst_n = 0;
    cyc(1);
    rst_n = 1;
    cyc(1);
    chk({go_done, flag, res}, 20'h0);
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
